// file: pkg/wdtsm_cfg.svh
`ifndef WDTSM_CFG_SVH
`define WDTSM_CFG_SVH
// Register byte addresses on the APB bus.
`define WDTSM_OFF_CTRL      12'h000
`define WDTSM_OFF_STATUS    12'h004
`define WDTSM_OFF_IRQ_STAT  12'h008
`define WDTSM_OFF_IRQ_EN    12'h00c
`define WDTSM_OFF_IRQ_CLR   12'h010
// Control register layout.
`define WDTSM_CTRL_EN_BIT   0
`define WDTSM_PS_LSB        1
`define WDTSM_PS_MSB        5
`define WDTSM_PS_RESET      5'h0b
`define WDTSM_PS_MAX        5'h12
// Prescale of code zero is 2^5 ticks of the low-frequency oscillator.
`define WDTSM_PS_BASE_LOG2  5
// Mode configuration codes.
`define WDTSM_MODE_OFF      2'h0
`define WDTSM_MODE_SW       2'h1
`define WDTSM_MODE_NOSLP    2'h2
`define WDTSM_MODE_ON       2'h3
// Status register bits.
`define WDTSM_ST_TO_BIT     0
`define WDTSM_ST_PD_BIT     1
`define WDTSM_ST_ACT_BIT    2
`define WDTSM_ST_SLP_BIT    3
// Interrupt bits.
`define WDTSM_IRQ_RST_BIT   0
`define WDTSM_IRQ_WAKE_BIT  1
`define WDTSM_IRQ_W         2
// Time base.
`define WDTSM_CLK_HZ        100000000
`define WDTSM_LFOSC_HZ      31000
`endif

// file: pkg/wdtsm_pkg.sv
package wdtsm_pkg;
   typedef enum logic [1:0] {
      WDTSM_AWAKE,
      WDTSM_ASLEEP,
      WDTSM_OST_HOLD
   } wdtsm_pwr_t;
endpackage : wdtsm_pkg

// file: core/wdtsm_lfosc_tick.sv
`timescale 1ns/10ps
`include "wdtsm_cfg.svh"
module wdtsm_lfosc_tick #(
   parameter int unsigned CLK_HZ = `WDTSM_CLK_HZ,
   parameter int unsigned OSC_HZ = `WDTSM_LFOSC_HZ
) (
   input  wire logic pclk,
   input  wire logic presetn,
   output logic      tick
);
   localparam int unsigned DIV = CLK_HZ / OSC_HZ;
   localparam int unsigned CW  = $clog2(DIV + 1);
   initial begin
      if (DIV < 1) $error("wdtsm_lfosc_tick: oscillator faster than clock");
   end
   typedef struct packed {
      logic [CW-1:0] cnt;
      logic          tick;
   } wdtsm_tick_st_t;
   wdtsm_tick_st_t s_q, s_d;
   always_comb begin
      s_d      = s_q;
      s_d.tick = 1'b0;
      if (s_q.cnt == CW'(DIV - 1)) begin
         s_d.cnt  = '0;
         s_d.tick = 1'b1;
      end else begin
         s_d.cnt = s_q.cnt + CW'(1);
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
   assign tick = s_q.tick;
endmodule : wdtsm_lfosc_tick

// file: core/wdtsm_top.sv
`timescale 1ns/10ps
`include "wdtsm_cfg.svh"
// What this block does
// - Time base is a tick of the 31 kHz low-frequency oscillator, 1 ms per 32.
// - Mode 11: watchdog always active, Sleep included, software enable ignored.
// - Mode 10: active while awake, disabled in Sleep.
// - Mode 01: active exactly when the software enable bit is set.
// - Mode 00: always disabled; software enable ignored here and in modes 1x.
// - Period code 0 is 1:32, each step doubles, up to code 10010 at 1:8388608.
// - Period codes 10011 to 11111 act as the minimum 1:32 interval.
// - After reset the period code is 01011, a 1:65536 two-second time-out.
// - Count clears on reset, clear instruction, Sleep entry, wake, osc fail, disable.
// - After wake with a crystal mode, count stays clear until start-up timer ends.
// - Changing the internal oscillator divider leaves the count alone.
// - Sleep entry clears the count; an active watchdog then counts from zero.
// - Time-out in Sleep wakes the device, no reset, and updates both status flags.
// - Control bits 7 and 6 read zero; software enable is bit 0, reset to 0.
// - Period select occupies control bits 5 to 1, read and write.
// - Time-out while awake generates a device reset.
module wdtsm_top
   import wdtsm_pkg::*;
#(
   parameter int unsigned PS_W   = 5,
   parameter int unsigned CNT_W  = 24,
   parameter int unsigned CLK_HZ = `WDTSM_CLK_HZ
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [1:0]  watchdog_mode_cfg,
   input  wire logic        clear_watchdog_instr,
   input  wire logic        sleep_instr,
   input  wire logic        wake_event,
   input  wire logic        osc_fail,
   input  wire logic        crystal_osc_sel,
   input  wire logic        osc_startup_timer,
   input  wire logic [3:0]  internal_osc_divider_sel,
   output logic             wdt_reset,
   output logic             wdt_wake,
   output logic             sleeping,
   output logic             timeout_flag_n,
   output logic             powerdown_flag_n,
   output logic             irq
);
   initial begin
      if (PS_W != 5) $error("wdtsm_top: period select must be 5 bits");
      if (CNT_W != 24) $error("wdtsm_top: counter must be 24 bits for 1:8388608");
      if (CLK_HZ < `WDTSM_LFOSC_HZ) $error("wdtsm_top: clock slower than the oscillator");
   end

   typedef struct packed {
      logic                      fail_s1;
      logic                      fail_s2;
      logic                      ost_s1;
      logic                      ost_s2;
      logic [PS_W-1:0]           period_sel;
      logic                      soft_en;
      logic [CNT_W-1:0]          cnt;
      wdtsm_pwr_t                pwr;
      logic                      slp;
      logic                      to_n;
      logic                      pd_n;
      logic                      rst_p;
      logic                      wake_p;
      logic [`WDTSM_IRQ_W-1:0]   irq_stat;
      logic [`WDTSM_IRQ_W-1:0]   irq_en;
      logic                      irq;
      logic [31:0]               rdata;
      logic                      ready;
      logic                      slverr;
   } wdtsm_st_t;

   wdtsm_st_t s_q, s_d;
   logic      lf_tick;

   wdtsm_lfosc_tick #(
      .CLK_HZ (CLK_HZ)
   ) u_tick (
      .pclk    (pclk),
      .presetn (presetn),
      .tick    (lf_tick)
   );

   logic             active;
   logic             asleep;
   logic [CNT_W-1:0] limit;
   logic             expire;
   logic             setup;
   logic             wr_ok;
   logic             hit;
   logic [`WDTSM_IRQ_W-1:0] ev;
   logic [`WDTSM_IRQ_W-1:0] stat_n;

   // Active level from the mode table.
   always_comb begin
      asleep = (s_q.pwr != WDTSM_AWAKE);
      unique case (watchdog_mode_cfg)
         `WDTSM_MODE_ON:    active = 1'b1;
         `WDTSM_MODE_NOSLP: active = !asleep;
         `WDTSM_MODE_SW:    active = s_q.soft_en;
         `WDTSM_MODE_OFF:   active = 1'b0;
      endcase
   end

   // Terminal count; reserved codes fall back to the minimum interval.
   always_comb begin
      if (s_q.period_sel > `WDTSM_PS_MAX) begin
         limit = CNT_W'(1) << `WDTSM_PS_BASE_LOG2;
      end else begin
         limit = CNT_W'(1) << (`WDTSM_PS_BASE_LOG2 + s_q.period_sel);
      end
   end

   assign expire = active && lf_tick && (s_q.cnt == limit - CNT_W'(1));
   assign setup  = psel && !penable;
   // A write lands at the edge where the master sees pready high.
   assign wr_ok  = psel && penable && pwrite && s_q.ready;

   always_comb begin
      s_d         = s_q;
      s_d.fail_s1 = osc_fail;
      s_d.fail_s2 = s_q.fail_s1;
      s_d.ost_s1  = osc_startup_timer;
      s_d.ost_s2  = s_q.ost_s1;
      s_d.rst_p   = 1'b0;
      s_d.wake_p  = 1'b0;
      ev          = '0;
      hit         = 1'b1;

      // Counting; the divider select is deliberately not an input to this path.
      if (!active || s_q.fail_s2 || clear_watchdog_instr) begin
         s_d.cnt = '0;
      end else if (expire) begin
         s_d.cnt = '0;
      end else if (lf_tick) begin
         s_d.cnt = s_q.cnt + CNT_W'(1);
      end

      if (clear_watchdog_instr) begin
         s_d.to_n = 1'b1;
         s_d.pd_n = 1'b1;
      end

      unique case (s_q.pwr)
         WDTSM_AWAKE: begin
            if (expire) begin
               s_d.rst_p = 1'b1;
               s_d.to_n  = 1'b0;
               ev[`WDTSM_IRQ_RST_BIT] = 1'b1;
            end else if (sleep_instr) begin
               s_d.pwr  = WDTSM_ASLEEP;
               s_d.cnt  = '0;
               s_d.pd_n = 1'b0;
               s_d.to_n = 1'b1;
            end
         end
         WDTSM_ASLEEP: begin
            if (expire || wake_event) begin
               s_d.cnt    = '0;
               s_d.wake_p = 1'b1;
               s_d.pwr    = crystal_osc_sel ? WDTSM_OST_HOLD : WDTSM_AWAKE;
               if (expire) begin
                  s_d.to_n = 1'b0;
                  s_d.pd_n = 1'b0;
                  ev[`WDTSM_IRQ_WAKE_BIT] = 1'b1;
               end
            end
         end
         WDTSM_OST_HOLD: begin
            s_d.cnt = '0;
            if (!s_q.ost_s2) begin
               s_d.pwr = WDTSM_AWAKE;
            end
         end
      endcase
      s_d.slp = (s_d.pwr == WDTSM_ASLEEP);

      // APB slave: answers in the access cycle, one wait-free cycle after setup.
      s_d.ready  = setup;
      s_d.slverr = 1'b0;
      s_d.rdata  = '0;
      stat_n     = s_q.irq_stat;
      unique case (paddr)
         `WDTSM_OFF_CTRL: begin
            s_d.rdata[`WDTSM_PS_MSB:`WDTSM_PS_LSB]  = s_q.period_sel;
            s_d.rdata[`WDTSM_CTRL_EN_BIT]           = s_q.soft_en;
            if (wr_ok) begin
               s_d.period_sel = pwdata[`WDTSM_PS_MSB:`WDTSM_PS_LSB];
               s_d.soft_en    = pwdata[`WDTSM_CTRL_EN_BIT];
            end
         end
         `WDTSM_OFF_STATUS: begin
            s_d.rdata[`WDTSM_ST_TO_BIT]  = s_q.to_n;
            s_d.rdata[`WDTSM_ST_PD_BIT]  = s_q.pd_n;
            s_d.rdata[`WDTSM_ST_ACT_BIT] = active;
            s_d.rdata[`WDTSM_ST_SLP_BIT] = asleep;
         end
         `WDTSM_OFF_IRQ_STAT: s_d.rdata[`WDTSM_IRQ_W-1:0] = s_q.irq_stat;
         `WDTSM_OFF_IRQ_EN: begin
            s_d.rdata[`WDTSM_IRQ_W-1:0] = s_q.irq_en;
            if (wr_ok) begin
               s_d.irq_en = pwdata[`WDTSM_IRQ_W-1:0];
            end
         end
         `WDTSM_OFF_IRQ_CLR: begin
            if (wr_ok) begin
               stat_n = s_q.irq_stat & ~pwdata[`WDTSM_IRQ_W-1:0];
            end
         end
         default: hit = 1'b0;
      endcase
      if (setup && !hit) begin
         s_d.slverr = 1'b1;
      end
      // A new event wins over a clear in the same cycle.
      s_d.irq_stat = stat_n | ev;
      s_d.irq      = |(s_d.irq_stat & s_d.irq_en);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q            <= '0;
         s_q.period_sel <= `WDTSM_PS_RESET;
         s_q.soft_en    <= 1'b0;
         s_q.pwr        <= WDTSM_AWAKE;
         s_q.to_n       <= 1'b1;
         s_q.pd_n       <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   assign prdata           = s_q.rdata;
   assign pready           = s_q.ready;
   assign pslverr          = s_q.slverr;
   assign wdt_reset        = s_q.rst_p;
   assign wdt_wake         = s_q.wake_p;
   assign sleeping         = s_q.slp;
   assign timeout_flag_n   = s_q.to_n;
   assign powerdown_flag_n = s_q.pd_n;
   assign irq              = s_q.irq;

   sequence wdtsm_go_sleep_s;
      !asleep && sleep_instr && !expire;
   endsequence
   sequence wdtsm_cnt_zero_s;
      s_q.cnt == '0;
   endsequence

   reset_awake_a: assert property (@(posedge pclk) disable iff (!presetn)
      (expire && !asleep) |=> (wdt_reset && !timeout_flag_n))
      else $error("awake expiry gave no reset");
   sleep_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
      wdtsm_go_sleep_s |=> (wdtsm_cnt_zero_s and !powerdown_flag_n and sleeping))
      else $error("sleep entry did not clear count");
   sleep_wake_a: assert property (@(posedge pclk) disable iff (!presetn)
      (expire && sleeping) |=> (wdt_wake && !wdt_reset && !timeout_flag_n))
      else $error("sleep expiry misbehaved");
   off_mode_a: assert property (@(posedge pclk) disable iff (!presetn)
      (watchdog_mode_cfg == `WDTSM_MODE_OFF) |-> !active)
      else $error("watchdog active in off mode");
   on_mode_a: assert property (@(posedge pclk) disable iff (!presetn)
      (watchdog_mode_cfg == `WDTSM_MODE_ON) |-> active)
      else $error("watchdog idle in always-on mode");
   nosleep_mode_a: assert property (@(posedge pclk) disable iff (!presetn)
      (watchdog_mode_cfg == `WDTSM_MODE_NOSLP) |-> (active == !asleep))
      else $error("off-in-sleep mode wrong");
   sw_mode_a: assert property (@(posedge pclk) disable iff (!presetn)
      (watchdog_mode_cfg == `WDTSM_MODE_SW) |-> (active == s_q.soft_en))
      else $error("software mode wrong");
   disable_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
      (!active || clear_watchdog_instr) |=> wdtsm_cnt_zero_s)
      else $error("count not cleared");
   ost_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
      (s_q.pwr == WDTSM_OST_HOLD) |=> wdtsm_cnt_zero_s)
      else $error("count moved during start-up timer");
   reserved_ps_a: assert property (@(posedge pclk) disable iff (!presetn)
      (s_q.period_sel > `WDTSM_PS_MAX) |-> (limit == (CNT_W'(1) << `WDTSM_PS_BASE_LOG2)))
      else $error("reserved period not minimum");
   clear_watchdog_instr_flags_a: assert property (@(posedge pclk) disable iff (!presetn)
      (clear_watchdog_instr && !expire && !sleep_instr) |=> (timeout_flag_n && powerdown_flag_n))
      else $error("clear did not set flags");
   ctrl_read_a: assert property (@(posedge pclk) disable iff (!presetn)
      (setup && !pwrite && paddr == `WDTSM_OFF_CTRL) |=> (prdata[7:6] == 2'h0 && pready))
      else $error("control upper bits not zero");
endmodule : wdtsm_top

// file: sim/wdtsm_core_model.sv
`timescale 1ns/10ps
module wdtsm_core_model (
   input  wire logic pclk,
   input  wire logic presetn,
   output logic      clear_watchdog_instr,
   output logic      sleep_instr,
   output logic      wake_event
);
   initial begin
      clear_watchdog_instr = 1'b0;
      sleep_instr = 1'b0;
      wake_event = 1'b0;
   end
   // Kind 0 clears the watchdog, 1 enters Sleep, other values wake; each is a one-cycle pulse.
   task automatic issue(input int kind);
      @(posedge pclk);
      case (kind)
         0: clear_watchdog_instr <= 1'b1;
         1: sleep_instr <= 1'b1;
         default: wake_event <= 1'b1;
      endcase
      @(posedge pclk);
      clear_watchdog_instr <= 1'b0;
      sleep_instr <= 1'b0;
      wake_event <= 1'b0;
   endtask : issue
endmodule : wdtsm_core_model

// file: sim/wdtsm_top_tb.sv
`timescale 1ns/10ps
`include "wdtsm_cfg.svh"
module wdtsm_top_tb;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [1:0]  watchdog_mode_cfg;
   logic [3:0]  internal_osc_divider_sel;
   logic        clear_watchdog_instr, sleep_instr, wake_event, osc_fail;
   logic        crystal_osc_sel, osc_startup_timer, wdt_reset, wdt_wake;
   logic        sleeping, timeout_flag_n, powerdown_flag_n, irq, act, sact;
   int          fails, n_checks, n_rst, n_wake, cyc, r, m, e;
   // Oscillator tick every DIV clocks keeps the long time-outs short in simulation.
   localparam int unsigned DIV = 100;

   wdtsm_top #(
      .CLK_HZ (DIV * `WDTSM_LFOSC_HZ)
   ) dut_u (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .watchdog_mode_cfg, .clear_watchdog_instr, .sleep_instr, .wake_event,
      .osc_fail, .crystal_osc_sel, .osc_startup_timer, .internal_osc_divider_sel,
      .wdt_reset, .wdt_wake, .sleeping, .timeout_flag_n, .powerdown_flag_n, .irq
   );
   wdtsm_core_model core_u (
      .pclk, .presetn, .clear_watchdog_instr, .sleep_instr, .wake_event
   );

   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   // Counting cycles of high level also proves that each pulse lasts one cycle.
   always @(posedge pclk) begin
      if (wdt_reset === 1'b1) begin
         n_rst <= n_rst + 1;
      end
      if (wdt_wake === 1'b1) begin
         n_wake <= n_wake + 1;
      end
   end

   task automatic summarize();
      $display("checks %0d fails %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : summarize

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
         fails++;
      end
   endtask : chk

   // Ready is sampled at the rising edge; data is taken and the request released there.
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      int i;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      for (i = 0; i < 16; i++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (i == 16) begin
         fails++;
         summarize();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rdchk(input string what, input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(what, exp, rd);
   endtask : rdchk

   task automatic irqchk(input logic exp);
      @(negedge pclk);
      chk("irq", {31'h0, exp}, {31'h0, irq});
   endtask : irqchk

   initial begin
      {presetn, psel, penable, pwrite, osc_fail, crystal_osc_sel, osc_startup_timer} = '0;
      {paddr, pwdata, watchdog_mode_cfg, internal_osc_divider_sel} = '0;
      {fails, n_checks, n_rst, n_wake} = '0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      rdchk("ctrl reset", `WDTSM_OFF_CTRL, 32'h16);
      rdchk("status reset", `WDTSM_OFF_STATUS, 32'h3);
      apb(1'b1, `WDTSM_OFF_CTRL, 32'hffffffff);
      rdchk("ctrl bits", `WDTSM_OFF_CTRL, 32'h3f);
      apb(1'b1, `WDTSM_OFF_CTRL, 32'h26);
      rdchk("ctrl period", `WDTSM_OFF_CTRL, 32'h26);
      apb(1'b0, 12'h014, 32'h0);
      chk("unmapped error", 32'h1, {31'h0, err});
      $display("test registers done");
      for (m = 0; m < 4; m++) begin
         for (e = 0; e < 2; e++) begin
            watchdog_mode_cfg <= m[1:0];
            apb(1'b1, `WDTSM_OFF_CTRL, {31'h0, e[0]});
            core_u.issue(0);
            act = (m >= 2) || (m == 1 && e == 1);
            sact = (m == 3) || (m == 1 && e == 1);
            rdchk("awake", `WDTSM_OFF_STATUS, {29'h0, act, 2'h3});
            core_u.issue(1);
            rdchk("asleep", `WDTSM_OFF_STATUS, {28'h1, sact, 2'h1});
            r = n_wake;
            core_u.issue(2);
            rdchk("woken", `WDTSM_OFF_STATUS, {29'h0, act, 2'h1});
            chk("wake pulse", r + 1, n_wake);
         end
      end
      $display("test modes done");
      watchdog_mode_cfg <= 2'h3;
      apb(1'b1, `WDTSM_OFF_CTRL, 32'h0);
      core_u.issue(1);
      r = n_wake;
      e = n_rst;
      for (cyc = 0; cyc < 4000 && n_wake == r; cyc++) begin
         @(posedge pclk);
      end
      chk("sleep timeout cycles", 32'h1, {31'h0, cyc >= 31 * DIV - 4 && cyc <= 32 * DIV + 8});
      watchdog_mode_cfg <= 2'h0;
      chk("sleep no reset", e, n_rst);
      chk("awake after timeout", 32'h0, {31'h0, sleeping});
      rdchk("status sleep timeout", `WDTSM_OFF_STATUS, 32'h0);
      $display("test sleep timeout done");
      apb(1'b1, `WDTSM_OFF_IRQ_STAT, 32'h3);
      rdchk("irq status", `WDTSM_OFF_IRQ_STAT, 32'h2);
      irqchk(1'b0);
      apb(1'b1, `WDTSM_OFF_IRQ_EN, 32'h2);
      irqchk(1'b1);
      apb(1'b1, `WDTSM_OFF_IRQ_EN, 32'h0);
      irqchk(1'b0);
      apb(1'b1, `WDTSM_OFF_IRQ_CLR, 32'h2);
      rdchk("irq cleared", `WDTSM_OFF_IRQ_STAT, 32'h0);
      rdchk("irq clear reg", `WDTSM_OFF_IRQ_CLR, 32'h0);
      apb(1'b1, `WDTSM_OFF_IRQ_EN, 32'h1);
      irqchk(1'b0);
      $display("test interrupt done");
      watchdog_mode_cfg <= 2'h1;
      apb(1'b1, `WDTSM_OFF_CTRL, 32'h1);
      r = n_rst;
      core_u.issue(0);
      for (cyc = 0; cyc < 4000 && n_rst == r; cyc++) begin
         @(posedge pclk);
         if (cyc == 1000) begin
            internal_osc_divider_sel <= 4'h7;
         end
      end
      chk("timeout cycles", 32'h1, {31'h0, cyc >= 31 * DIV - 4 && cyc <= 32 * DIV + 8});
      repeat (4) @(posedge pclk);
      chk("reset pulse", r + 1, n_rst);
      rdchk("status timeout", `WDTSM_OFF_STATUS, 32'h6);
      rdchk("irq reset bit", `WDTSM_OFF_IRQ_STAT, 32'h1);
      irqchk(1'b1);
      $display("test timeout done");
      summarize();
   end
endmodule : wdtsm_top_tb
